// ### irdc_ir_tx.sv
// Behavioural infrared remote transmitter seen through the receiver module
`timescale 1ns/10ps
`default_nettype none

module irdc_ir_tx (
   output var logic ir_receive_pin,
   input wire logic sys_clk
);
   // ======================================================================
   // Line timing, 1 cycle stands for 100 us of air time
   localparam int T_LEAD = 90;
   localparam int T_DSP = 45;
   localparam int T_RSP = 22;
   localparam int T_MARK = 6;
   localparam int T_SP0 = 5;
   localparam int T_SP1 = 16;

   // Receiver output idles high; low means carrier is present
   initial ir_receive_pin = 1'b1;

   // Drive one level for n cycles, changing just after an edge
   task automatic hold(input logic lv, input int n);
      ir_receive_pin <= lv;
      repeat (n) @(posedge sys_clk);
   endtask : hold

   // Leader, customer code, data code and its complement, stop mark, LSB first
   task automatic send_frame(input logic [15:0] cust, input logic [7:0] code);
      logic [31:0] w;
      w = {~code, code, cust};
      hold(1'b0, T_LEAD);
      hold(1'b1, T_DSP);
      for (int b = 0; b < 32; b++) begin
         hold(1'b0, T_MARK);
         hold(1'b1, w[b] ? T_SP1 : T_SP0);
      end
      hold(1'b0, T_MARK);
      hold(1'b1, 1);
   endtask : send_frame

   // Short leader space then a lone stop mark, sent while a key stays held
   task automatic send_repeat();
      hold(1'b0, T_LEAD);
      hold(1'b1, T_RSP);
      hold(1'b0, T_MARK);
      hold(1'b1, 1);
   endtask : send_repeat
endmodule : irdc_ir_tx

`default_nettype wire

// ### irdc_pkg.sv
// Constants, enumerations and register map of the infrared dimming controller
package irdc_pkg;

   // ======================================================================
   // Clock and link timing
   localparam int CLK_MHZ = 100;
   localparam int LEADER_MARK_MIN_US = 8000;   // Leader mark is nominally 9 ms
   localparam int DATA_SPACE_MIN_US = 3375;    // Data leader space 4.5 ms
   localparam int REP_SPACE_MIN_US = 1700;     // Repeat leader space 2.25 ms
   localparam int BIT_ONE_MIN_US = 1688;       // Bit period 1.125 ms (0) or 2.25 ms (1)
   localparam int LINK_TIMEOUT_US = 12000;     // Any mark or gap longer ends the frame
   localparam int WAKE_US = 100000;            // Periodic wake interval out of HALT
   localparam int STOP_IDLE_S = 10;            // Quiet time before STOP
   localparam int LEADER_MARK_MIN_CYC = LEADER_MARK_MIN_US * CLK_MHZ;
   localparam int DATA_SPACE_MIN_CYC = DATA_SPACE_MIN_US * CLK_MHZ;
   localparam int REP_SPACE_MIN_CYC = REP_SPACE_MIN_US * CLK_MHZ;
   localparam int BIT_ONE_MIN_CYC = BIT_ONE_MIN_US * CLK_MHZ;
   localparam int LINK_TIMEOUT_CYC = LINK_TIMEOUT_US * CLK_MHZ;
   localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
   localparam int STOP_IDLE_CYC = STOP_IDLE_S * 1000000 * CLK_MHZ;

   // ======================================================================
   // Frame content and dimming levels
   localparam logic [15:0] CUST_RST = 16'h1234;
   localparam logic [7:0] CMD_MAX = 8'h00;
   localparam logic [7:0] CMD_MID = 8'h01;
   localparam logic [7:0] CMD_OFF = 8'h02;
   localparam logic [7:0] CMD_UP = 8'h03;
   localparam logic [7:0] CMD_DOWN = 8'h04;
   localparam logic [7:0] LVL_MAX = 8'hff;
   localparam logic [7:0] LVL_MID = 8'h80;
   localparam logic [7:0] LVL_OFF = 8'h00;
   localparam logic [7:0] LVL_STEP = 8'h10;

   // ======================================================================
   // Register map and fields
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_CLR = 8'h04;
   localparam logic [7:0] REG_EN = 8'h08;
   localparam logic [7:0] REG_CUST = 8'h0c;
   localparam logic [7:0] REG_CMD = 8'h10;
   localparam logic [7:0] REG_LED = 8'h14;
   localparam int ST_DATA = 0;
   localparam int ST_REP = 1;
   localparam int ST_BAD = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ======================================================================
   // State enumerations
   typedef enum logic [2:0] {RX_IDLE, RX_LMARK, RX_LSPACE, RX_BITS} irdc_rx_t;
   typedef enum logic [1:0] {PW_RUN, PW_HALT, PW_STOP} irdc_pw_t;

endpackage : irdc_pkg

// ### irdc_top.sv
// Infrared remote receiver with three-channel dimming command task and power sequencing
// Functional notes
// - Codes 0,1,2 set max, mid, off
// - Codes 3,4 step; repeats apply again
// - Repeat reuses held code, raises repeat event
// - Data frame stores code, raises data event
// - Accept only matching customer code
// - Receive pin low means carrier
// - Capture timer measures bit period length
// - Interval timer detects leader code
// - Task stage loads targets into channels
// - Three channels: red, green, blue
// - No signal: standby, request HALT
// - HALT ends on activity or wake interval
// - STOP after 10 s quiet, LEDs off
// - Activity ends STOP, processing resumes
// - STOP is build option, off by default
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module irdc_top #(
   parameter bit STOP_EN = 1'b0,
   parameter logic [20:0] P_LEADER = 21'(irdc_pkg::LEADER_MARK_MIN_CYC),
   parameter logic [20:0] P_DSPACE = 21'(irdc_pkg::DATA_SPACE_MIN_CYC),
   parameter logic [20:0] P_RSPACE = 21'(irdc_pkg::REP_SPACE_MIN_CYC),
   parameter logic [20:0] P_ONE = 21'(irdc_pkg::BIT_ONE_MIN_CYC),
   parameter logic [20:0] P_TIMEOUT = 21'(irdc_pkg::LINK_TIMEOUT_CYC),
   parameter logic [23:0] P_WAKE = 24'(irdc_pkg::WAKE_CYC),
   parameter logic [29:0] P_STOP = 30'(irdc_pkg::STOP_IDLE_CYC)
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic ir_receive_pin,
   output logic [7:0] led_red,
   output logic [7:0] led_green,
   output logic [7:0] led_blue,
   output logic halt_req,
   output logic stop_req,
   output logic irq,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // ======================================================================
   // State record
   typedef struct packed {
      irdc_pkg::irdc_rx_t rx;
      irdc_pkg::irdc_pw_t pw;
      logic car;
      logic [20:0] ivl;
      logic [20:0] cap;
      logic [4:0] nb;
      logic [31:0] sh;
      logic [7:0] cmd;
      logic have;
      logic apply;
      logic aprep;
      logic [7:0] red;
      logic [7:0] grn;
      logic [7:0] blu;
      logic [29:0] since;
      logic [23:0] wake;
      logic [2:0] st;
      logic [2:0] en;
      logic [15:0] cust;
      logic awv;
      logic [7:0] awa;
      logic wv;
      logic [31:0] wd;
      logic [3:0] ws;
      logic bv;
      logic [1:0] br;
      logic rv;
      logic [31:0] rd;
      logic [1:0] rr;
   } irdc_state_t;

   irdc_state_t s_q;
   irdc_state_t s_d;
   logic carrier;
   logic bit_one;
   logic [31:0] word;
   logic evt_data;
   logic evt_rep;
   logic evt_bad;
   logic [2:0] clr;

   // Saturating step keeps the level inside the range at both ends
   function automatic logic [7:0] irdc_step(input logic [7:0] v, input logic up);
      logic [8:0] t;
      t = up ? ({1'b0, v} + {1'b0, irdc_pkg::LVL_STEP}) : ({1'b0, v} - {1'b0, irdc_pkg::LVL_STEP});
      if (t[8]) begin
         return up ? irdc_pkg::LVL_MAX : irdc_pkg::LVL_OFF;
      end
      return t[7:0];
   endfunction : irdc_step

   // Pin is active low
   assign carrier = ~ir_receive_pin;

   // ======================================================================
   // Next-state logic
   always_comb begin
      s_d = s_q;
      evt_data = 1'b0;
      evt_rep = 1'b0;
      evt_bad = 1'b0;
      clr = 3'h0;
      bit_one = (s_q.cap >= P_ONE);
      word = {bit_one, s_q.sh[31:1]};
      s_d.car = carrier;

      // Frame receiver: interval timer on the leader, capture timer on bits
      case (s_q.rx)
         irdc_pkg::RX_IDLE: begin
            s_d.ivl = 21'h0;
            if (carrier) begin
               s_d.rx = irdc_pkg::RX_LMARK;
            end
         end
         irdc_pkg::RX_LMARK: begin
            s_d.ivl = 21'(s_q.ivl + 21'h1);
            if (!carrier) begin
               s_d.ivl = 21'h0;
               s_d.rx = (s_q.ivl >= P_LEADER) ? irdc_pkg::RX_LSPACE : irdc_pkg::RX_IDLE;
            end else if (s_q.ivl >= P_TIMEOUT) begin
               s_d.rx = irdc_pkg::RX_IDLE;
            end
         end
         irdc_pkg::RX_LSPACE: begin
            s_d.ivl = 21'(s_q.ivl + 21'h1);
            if (carrier) begin
               s_d.cap = 21'h0;
               s_d.nb = 5'h0;
               if (s_q.ivl >= P_DSPACE) begin
                  s_d.rx = irdc_pkg::RX_BITS;
               end else begin
                  s_d.rx = irdc_pkg::RX_IDLE;
                  // Short space is a repeat; only meaningful once a code is held
                  evt_rep = (s_q.ivl >= P_RSPACE) && s_q.have;
               end
            end else if (s_q.ivl >= P_TIMEOUT) begin
               s_d.rx = irdc_pkg::RX_IDLE;
            end
         end
         irdc_pkg::RX_BITS: begin
            s_d.cap = 21'(s_q.cap + 21'h1);
            // Each new mark closes one bit period, mark start to mark start
            if (carrier && !s_q.car) begin
               s_d.cap = 21'h0;
               s_d.sh = word;
               s_d.nb = 5'(s_q.nb + 5'h1);
               if (s_q.nb == 5'h1f) begin
                  s_d.rx = irdc_pkg::RX_IDLE;
                  if (word[15:0] == s_q.cust && word[23:16] == ~word[31:24]) begin
                     evt_data = 1'b1;
                  end else begin
                     evt_bad = 1'b1;
                  end
               end
            end else if (s_q.cap >= P_TIMEOUT) begin
               s_d.rx = irdc_pkg::RX_IDLE;
            end
         end
         default: begin
            s_d.rx = irdc_pkg::RX_IDLE;
         end
      endcase

      // Command task: one cycle after an event the held code is applied
      s_d.apply = 1'b0;
      if (s_q.apply) begin
         case (s_q.cmd)
            irdc_pkg::CMD_MAX: begin
               if (!s_q.aprep) begin
                  s_d.red = irdc_pkg::LVL_MAX;
                  s_d.grn = irdc_pkg::LVL_MAX;
                  s_d.blu = irdc_pkg::LVL_MAX;
               end
            end
            irdc_pkg::CMD_MID: begin
               if (!s_q.aprep) begin
                  s_d.red = irdc_pkg::LVL_MID;
                  s_d.grn = irdc_pkg::LVL_MID;
                  s_d.blu = irdc_pkg::LVL_MID;
               end
            end
            irdc_pkg::CMD_OFF: begin
               if (!s_q.aprep) begin
                  s_d.red = irdc_pkg::LVL_OFF;
                  s_d.grn = irdc_pkg::LVL_OFF;
                  s_d.blu = irdc_pkg::LVL_OFF;
               end
            end
            irdc_pkg::CMD_UP, irdc_pkg::CMD_DOWN: begin
               s_d.red = irdc_step(s_q.red, s_q.cmd == irdc_pkg::CMD_UP);
               s_d.grn = irdc_step(s_q.grn, s_q.cmd == irdc_pkg::CMD_UP);
               s_d.blu = irdc_step(s_q.blu, s_q.cmd == irdc_pkg::CMD_UP);
            end
            default: begin
               s_d.red = s_q.red;
            end
         endcase
      end
      if (evt_data) begin
         s_d.cmd = word[23:16];
         s_d.have = 1'b1;
         s_d.apply = 1'b1;
         s_d.aprep = 1'b0;
      end else if (evt_rep) begin
         s_d.apply = 1'b1;
         s_d.aprep = 1'b1;
      end

      // Quiet time since the last accepted frame, saturating
      if (evt_data || evt_rep) begin
         s_d.since = 30'h0;
      end else if (s_q.since < P_STOP) begin
         s_d.since = 30'(s_q.since + 30'h1);
      end

      // Power sequencing; requests only, the logic itself keeps running
      case (s_q.pw)
         irdc_pkg::PW_RUN: begin
            s_d.wake = 24'h0;
            if (s_q.rx == irdc_pkg::RX_IDLE && !carrier && !s_q.apply) begin
               if (STOP_EN && s_q.since >= P_STOP && s_q.red == irdc_pkg::LVL_OFF
                   && s_q.grn == irdc_pkg::LVL_OFF && s_q.blu == irdc_pkg::LVL_OFF) begin
                  s_d.pw = irdc_pkg::PW_STOP;
               end else begin
                  s_d.pw = irdc_pkg::PW_HALT;
               end
            end
         end
         irdc_pkg::PW_HALT: begin
            s_d.wake = 24'(s_q.wake + 24'h1);
            if (carrier || s_q.wake >= P_WAKE) begin
               s_d.pw = irdc_pkg::PW_RUN;
            end
         end
         irdc_pkg::PW_STOP: begin
            if (carrier) begin
               s_d.pw = irdc_pkg::PW_RUN;
            end
         end
         default: begin
            s_d.pw = irdc_pkg::PW_RUN;
         end
      endcase

      // Bus write: address and data may arrive in either order
      if (s_axi_awvalid && s_axi_awready) begin
         s_d.awv = 1'b1;
         s_d.awa = s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_d.wv = 1'b1;
         s_d.wd = s_axi_wdata;
         s_d.ws = s_axi_wstrb;
      end
      if (s_q.awv && s_q.wv && !s_q.bv) begin
         s_d.awv = 1'b0;
         s_d.wv = 1'b0;
         s_d.bv = 1'b1;
         s_d.br = irdc_pkg::RESP_OKAY;
         case (s_q.awa)
            irdc_pkg::REG_CLR: clr = s_q.ws[0] ? s_q.wd[2:0] : 3'h0;
            irdc_pkg::REG_EN: s_d.en = s_q.ws[0] ? s_q.wd[2:0] : s_q.en;
            irdc_pkg::REG_CUST: begin
               s_d.cust[7:0] = s_q.ws[0] ? s_q.wd[7:0] : s_q.cust[7:0];
               s_d.cust[15:8] = s_q.ws[1] ? s_q.wd[15:8] : s_q.cust[15:8];
            end
            irdc_pkg::REG_STATUS, irdc_pkg::REG_CMD, irdc_pkg::REG_LED: s_d.br = irdc_pkg::RESP_OKAY;
            default: s_d.br = irdc_pkg::RESP_SLVERR;
         endcase
      end
      if (s_q.bv && s_axi_bready) begin
         s_d.bv = 1'b0;
      end

      // Bus read: one answer outstanding at a time
      if (s_axi_arvalid && s_axi_arready) begin
         s_d.rv = 1'b1;
         s_d.rr = irdc_pkg::RESP_OKAY;
         case (s_axi_araddr[7:0])
            irdc_pkg::REG_STATUS: s_d.rd = {29'h0, s_q.st};
            irdc_pkg::REG_CLR: s_d.rd = 32'h0;
            irdc_pkg::REG_EN: s_d.rd = {29'h0, s_q.en};
            irdc_pkg::REG_CUST: s_d.rd = {16'h0, s_q.cust};
            irdc_pkg::REG_CMD: s_d.rd = {21'h0, s_q.pw == irdc_pkg::PW_STOP,
                                         s_q.pw == irdc_pkg::PW_HALT, s_q.have, s_q.cmd};
            irdc_pkg::REG_LED: s_d.rd = {8'h0, s_q.red, s_q.grn, s_q.blu};
            default: begin
               s_d.rd = 32'h0;
               s_d.rr = irdc_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_q.rv && s_axi_rready) begin
         s_d.rv = 1'b0;
      end

      // Sticky events: a new event beats a clear in the same cycle
      s_d.st = (s_q.st & ~clr) | {evt_bad, evt_rep, evt_data};
   end

   // ======================================================================
   // State register
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s_q <= '0;
         s_q.cust <= irdc_pkg::CUST_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ======================================================================
   // Outputs
   assign led_red = s_q.red;
   assign led_green = s_q.grn;
   assign led_blue = s_q.blu;
   assign halt_req = (s_q.pw == irdc_pkg::PW_HALT);
   assign stop_req = (s_q.pw == irdc_pkg::PW_STOP);
   assign irq = |(s_q.st & s_q.en);
   // Ready stays low while a response is pending so nothing is overwritten
   assign s_axi_awready = !s_q.awv && !s_q.bv;
   assign s_axi_wready = !s_q.wv && !s_q.bv;
   assign s_axi_bvalid = s_q.bv;
   assign s_axi_bresp = s_q.br;
   assign s_axi_arready = !s_q.rv;
   assign s_axi_rvalid = s_q.rv;
   assign s_axi_rdata = s_q.rd;
   assign s_axi_rresp = s_q.rr;

   // ======================================================================
   // Assertions
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   pin_low_mark_a: assert property (
      s_q.rx == irdc_pkg::RX_IDLE && !ir_receive_pin |=> s_q.rx == irdc_pkg::RX_LMARK)
      else $error("low pin did not start a leader mark");

   max_level_a: assert property (
      evt_data && word[23:16] == irdc_pkg::CMD_MAX
      |-> ##2 (led_red == irdc_pkg::LVL_MAX && led_green == irdc_pkg::LVL_MAX && led_blue == irdc_pkg::LVL_MAX))
      else $error("code 0 did not light all channels at max");

   off_level_a: assert property (
      evt_data && word[23:16] == irdc_pkg::CMD_OFF
      |-> ##2 (led_red == 8'h00 && led_green == 8'h00 && led_blue == 8'h00))
      else $error("code 2 did not turn channels off");

   step_sat_a: assert property (
      s_q.apply && s_q.cmd == irdc_pkg::CMD_UP |=> led_red >= $past(led_red) && led_blue >= $past(led_blue))
      else $error("step up wrapped");

   data_store_a: assert property (
      evt_data |=> s_q.cmd == $past(word[23:16]) && s_q.st[irdc_pkg::ST_DATA] ##1 !s_q.apply)
      else $error("data frame not stored");

   repeat_keep_a: assert property (
      evt_rep |=> $stable(s_q.cmd) && s_q.apply && s_q.aprep && s_q.st[irdc_pkg::ST_REP])
      else $error("repeat did not reuse the held code");

   cust_reject_a: assert property (
      evt_bad |=> !s_q.apply && $stable(s_q.cmd) ##1 $stable(led_red))
      else $error("foreign customer code was acted on");

   halt_wake_a: assert property (
      halt_req && carrier |=> !halt_req && !stop_req)
      else $error("activity did not end HALT");

   stop_gate_a: assert property (
      $rose(stop_req) |-> STOP_EN && led_red == 8'h00 && led_green == 8'h00 && led_blue == 8'h00)
      else $error("STOP entered while disabled or lit");

   unknown_code_a: assert property (
      s_q.apply && s_q.cmd > irdc_pkg::CMD_DOWN |=> $stable(led_red) && $stable(led_green) && $stable(led_blue))
      else $error("unknown code changed a channel");

endmodule : irdc_top

`default_nettype wire

// ### test_ir_remote_dimming_control.sv
// Self-checking bench for the infrared dimming controller
`timescale 1ns/10ps
`default_nettype none

module test_ir_remote_dimming_control;
   // ======================================================================
   // Signals and design hookup
   logic sys_clk, rstn, ir_receive_pin, halt_req, stop_req, irq;
   logic [7:0] led_red, led_green, led_blue;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [15:0] cust;
   int fails, n_tests, lvl, last, seen, st, en, i;
   int ks[16] = '{1, 0, 1, 0, 1, 0, 0, 1, 0, 1, 0, 0, 1, 0, 1, 2};
   int cs[16] = '{5, 0, 0, 3, 0, 1, 3, 0, 4, 0, 2, 4, 0, 7, 0, 3};

   // Short counts keep the run brief; the ratios match the real link
   // Abort and wake keep full length: no frame is cut, and a wake never lands on a halt check
   irdc_top #(.P_LEADER(21'd80), .P_DSPACE(21'd34), .P_RSPACE(21'd17), .P_ONE(21'd17),
      .P_STOP(30'd2000)) uut (.sys_clk(sys_clk), .rstn(rstn),
      .ir_receive_pin(ir_receive_pin), .led_red(led_red), .led_green(led_green), .led_blue(led_blue),
      .halt_req(halt_req), .stop_req(stop_req), .irq(irq), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready));
   irdc_ir_tx tx (.ir_receive_pin(ir_receive_pin), .sys_clk(sys_clk));

   // 100 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // ======================================================================
   // Verdict, comparison and bus tasks
   task automatic conclude();
      if (fails == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Both channels offered together; bready held until the response is seen
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      // One edge between calls so bready is never lowered and raised in one step
      @(posedge sys_clk);
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 50);
      s_axi_bready <= 1'b0;
      rsp = s_axi_bresp;
      if (n >= 50) begin
         fails++;
         conclude();
      end
   endtask : bus_wr

   task automatic bus_rd(input logic [7:0] a);
      int n;
      n = 0;
      // One edge between calls so rready is never lowered and raised in one step
      @(posedge sys_clk);
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 50);
      s_axi_rready <= 1'b0;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      if (n >= 50) begin
         fails++;
         conclude();
      end
   endtask : bus_rd

   // Reference level update, saturating at both ends
   function automatic void step(input int c);
      case (c)
         0: lvl = 255;
         1: lvl = 128;
         2: lvl = 0;
         3: lvl = (lvl + 16 > 255) ? 255 : lvl + 16;
         4: lvl = (lvl < 16) ? 0 : lvl - 16;
         default: ;
      endcase
   endfunction : step

   // One frame: kind 0 data, 1 repeat, 2 foreign customer code
   task automatic run_op(input int kind, input int code);
      en = $urandom % 8;
      bus_wr(irdc_pkg::REG_EN, 32'(en), 4'hf);
      fork
         if (kind == 1) tx.send_repeat();
         else tx.send_frame(kind == 2 ? ~cust : cust, code[7:0]);
         begin
            repeat (30) @(posedge sys_clk);
            chk({31'h0, halt_req}, 32'h0);
         end
      join
      if (kind == 2) st |= 4;
      else if (kind == 0) begin
         st |= 1;
         seen = 1;
         last = code;
         step(code);
      end else if (seen != 0) begin
         st |= 2;
         if (last == 3 || last == 4) step(last);
      end
      chk({24'h0, led_red}, 32'(lvl));
      chk({24'h0, led_green}, 32'(lvl));
      chk({24'h0, led_blue}, 32'(lvl));
      bus_rd(irdc_pkg::REG_LED);
      chk(rd, {8'h0, lvl[7:0], lvl[7:0], lvl[7:0]});
      bus_rd(irdc_pkg::REG_STATUS);
      chk(rd, 32'(st));
      chk({31'h0, irq}, {31'h0, (st & en) != 0});
      bus_rd(irdc_pkg::REG_CMD);
      if (seen != 0) chk(rd & 32'h1ff, 32'h100 | 32'(last));
      bus_wr(irdc_pkg::REG_CLR, 32'h7, 4'hf);
      chk({30'h0, rsp}, {30'h0, irdc_pkg::RESP_OKAY});
      st = 0;
      bus_rd(irdc_pkg::REG_STATUS);
      chk(rd, 32'h0);
      chk({31'h0, irq}, 32'h0);
   endtask : run_op

   // ======================================================================
   // Main sequence
   initial begin
      rstn = 1'b0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
      s_axi_wstrb = 4'hf;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {fails, n_tests, lvl, last, seen, st, en} = '0;
      cust = 16'h1234;
      void'($urandom(32'hf57612d8));
      repeat (10) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      chk({led_red, led_green, led_blue, 8'h0}, 32'h0);
      bus_rd(irdc_pkg::REG_CUST);
      chk(rd, 32'h1234);
      bus_rd(irdc_pkg::REG_EN);
      chk(rd, 32'h0);
      bus_rd(8'h40);
      chk({rd[29:0], rsp}, {30'h0, irdc_pkg::RESP_SLVERR});
      bus_wr(8'h44, 32'h5, 4'hf);
      chk({30'h0, rsp}, {30'h0, irdc_pkg::RESP_SLVERR});
      bus_rd(irdc_pkg::REG_CLR);
      chk(rd, 32'h0);
      chk({31'h0, halt_req}, 32'h1);
      // Fixed walk through every code, repeats and saturation, then random traffic
      for (i = 0; i < 16; i++) run_op(ks[i], cs[i]);
      for (i = 0; i < 20; i++) run_op($urandom % 3, $urandom % 8);
      // New customer code, high lane written apart from the low lane
      cust = 16'($urandom);
      if (cust == 16'h1234) cust = 16'h4321;
      bus_wr(irdc_pkg::REG_CUST, {16'h0, cust}, 4'h3);
      bus_wr(irdc_pkg::REG_CUST, 32'h0, 4'h2);
      cust[15:8] = 8'h0;
      bus_rd(irdc_pkg::REG_CUST);
      chk(rd, {16'h0, cust});
      run_op(0, 0);
      run_op(2, 2);
      run_op(0, 2);
      // Long quiet spell with LEDs off; STOP stays out when not built in
      repeat (2100) @(posedge sys_clk);
      chk({31'h0, stop_req}, 32'h0);
      chk({31'h0, halt_req}, 32'h1);
      bus_rd(irdc_pkg::REG_CMD);
      chk(rd & 32'h600, 32'h200);
      run_op(0, 1);
      conclude();
   end
endmodule : test_ir_remote_dimming_control

`default_nettype wire
